// file: design/lgicr_regs.sv
// link general and i2c configuration register bank with the logic the
// fields steer: sync filters, pixel gating, pass-through decision,
// auto-acknowledge, return path enable and control channel watchdog.
// assumes the local i2c target decodes register accesses into a simple
// synchronous strobe port, and all inputs are synchronous to clk_i.
//
// Overview of operation
// - filter on: reject sync pulses under two clocks
// - line sync filter: two clocks single, four dual
// - pull select: one pulls down, zero pulls up
// - return crc generator follows its enable bit
// - pass-through bit forwards address-matched i2c transactions
// - auto-acknowledge acks writes regardless of lock
// - protected partner: always gate pixels by valid
// - plain partner: gate only when gating bit set
// - seven-bit timeout field counts two millisecond steps
// - abort control transaction when watchdog timeout expires
// - timeout disable bit stops the watchdog entirely
// - forward-all bit forwards every i2c transaction
// - three-bit sda hold field, fifty nanosecond steps
// - four-bit glitch reject field, five nanosecond steps
// - return path off only if both pass bits low
module lgicr_regs #(
  parameter int unsigned WDOG_STEP_CYC = lgicr_pkg::WDOG_STEP_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // local register port from the i2c target
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // link status
  input  wire logic        dual_lane_i,
  input  wire logic        partner_protected_i,
  input  wire logic        fwd_locked_i,
  input  wire logic        return_path_on_i,
  // recovered video in
  input  wire logic        pixel_valid_strobe_i,
  input  wire logic        line_sync_i,
  input  wire logic        frame_sync_i,
  input  wire logic [23:0] pixel_data_i,
  // filtered and gated video out
  output logic             pixel_valid_strobe_o,
  output logic             line_sync_o,
  output logic             frame_sync_o,
  output logic [23:0]      pixel_data_o,
  // local i2c transaction decision
  input  wire logic        i2c_txn_start_i,
  input  wire logic        i2c_addr_match_i,
  input  wire logic        i2c_write_i,
  output logic             i2c_forward_o,
  output logic             i2c_write_ack_o,
  // control channel transaction watchdog
  input  wire logic        cc_txn_busy_i,
  output logic             cc_txn_abort_o,
  // static controls to pads and link
  output logic             undriven_pull_down_o,
  output logic             return_crc_gen_on_o,
  output logic             return_path_active_o,
  output logic [2:0]       sda_hold_steps_o,
  output logic [3:0]       glitch_reject_steps_o
);

  // register state
  logic [7:0] gen_cfg_q;
  logic [7:0] gen_cfg_d;
  logic [7:0] timeout_ctrl_q;
  logic [7:0] timeout_ctrl_d;
  logic [7:0] i2c_ctrl_one_q;
  logic [7:0] i2c_ctrl_one_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // field views
  logic       filter_on;
  logic       pass_matched;
  logic       pass_all;
  logic       auto_ack;
  logic       gate_bit;
  logic [6:0] return_path_timeout;
  logic       return_path_timeout_off;

  assign filter_on    = gen_cfg_q[lgicr_pkg::GC_FILTER_BIT];
  assign pass_matched = gen_cfg_q[lgicr_pkg::GC_PASS_BIT];
  assign auto_ack     = gen_cfg_q[lgicr_pkg::GC_AUTO_ACK_BIT];
  assign gate_bit     = gen_cfg_q[lgicr_pkg::GC_GATE_BIT];
  assign pass_all     = i2c_ctrl_one_q[lgicr_pkg::IC_PASS_ALL_BIT];
  assign return_path_timeout =
    timeout_ctrl_q[lgicr_pkg::TO_FIELD_LSB +: 7];
  assign return_path_timeout_off =
    timeout_ctrl_q[lgicr_pkg::TO_OFF_BIT];

  // register writes; bit 0 of general_config_one stays zero
  always_comb begin
    gen_cfg_d      = gen_cfg_q;
    timeout_ctrl_d = timeout_ctrl_q;
    i2c_ctrl_one_d = i2c_ctrl_one_q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        lgicr_pkg::OFS_GEN_CFG_ONE: begin
          // bit 7 is stored as written; software is expected to keep it
          gen_cfg_d = reg_wdata_i & lgicr_pkg::GC_WRITE_MASK;
        end
        lgicr_pkg::OFS_TIMEOUT_CTRL: begin
          timeout_ctrl_d = reg_wdata_i;
        end
        lgicr_pkg::OFS_I2C_CTRL_ONE: begin
          i2c_ctrl_one_d = reg_wdata_i;
        end
        default: begin
          // unmapped or read-only offsets: write ignored
        end
      endcase
    end
  end

  // read data, valid the cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      case (reg_addr_i)
        lgicr_pkg::OFS_GEN_CFG_ONE:  rdata_d = gen_cfg_q;
        lgicr_pkg::OFS_TIMEOUT_CTRL: rdata_d = timeout_ctrl_q;
        lgicr_pkg::OFS_I2C_CTRL_ONE: rdata_d = i2c_ctrl_one_q;
        lgicr_pkg::OFS_I2C_CTRL_TWO: rdata_d = lgicr_pkg::RST_I2C_CTRL_TWO;
        default:                     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gen_cfg_q      <= lgicr_pkg::RST_GEN_CFG_ONE;
      timeout_ctrl_q <= lgicr_pkg::RST_TIMEOUT_CTRL;
      i2c_ctrl_one_q <= lgicr_pkg::RST_I2C_CTRL_ONE;
      rdata_q        <= 8'h00;
    end else begin
      gen_cfg_q      <= gen_cfg_d;
      timeout_ctrl_q <= timeout_ctrl_d;
      i2c_ctrl_one_q <= i2c_ctrl_one_d;
      rdata_q        <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // static fields out to pads, crc generator and i2c front end
  assign undriven_pull_down_o =
    gen_cfg_q[lgicr_pkg::GC_PULL_SEL_BIT];
  assign return_crc_gen_on_o =
    gen_cfg_q[lgicr_pkg::GC_CRC_GEN_BIT];
  assign sda_hold_steps_o =
    i2c_ctrl_one_q[lgicr_pkg::IC_HOLD_LSB +: 3];
  assign glitch_reject_steps_o =
    i2c_ctrl_one_q[lgicr_pkg::IC_FILTER_LSB +: 4];

  // return path may only drop when neither pass-through mode needs it
  assign return_path_active_o =
    return_path_on_i | pass_matched | pass_all;

  // sync filters: one per video control input
  logic [2:0] sync_raw;
  logic [2:0] sync_filt;
  logic [2:0] sync_width [3];

  assign sync_raw   = {frame_sync_i, line_sync_i, pixel_valid_strobe_i};
  assign sync_width[0] = lgicr_pkg::FILT_W_SYNC;
  // line sync needs a wider window when two lanes are interleaved
  assign sync_width[1] = dual_lane_i ? lgicr_pkg::FILT_W_LINE_2
                                     : lgicr_pkg::FILT_W_LINE_1;
  assign sync_width[2] = lgicr_pkg::FILT_W_SYNC;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync_filt
      lgicr_pulse_filter u_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (filter_on),
        .width_i (sync_width[gi]),
        .d_i     (sync_raw[gi]),
        .q_o     (sync_filt[gi])
      );
    end
  endgenerate

  assign pixel_valid_strobe_o = sync_filt[0];
  assign line_sync_o          = sync_filt[1];
  assign frame_sync_o         = sync_filt[2];

  // pixel gating; a protected partner forces gating whatever the bit
  logic        gate_on;
  logic [23:0] pix_q;
  logic [23:0] pix_d;

  assign gate_on = partner_protected_i | gate_bit;

  // gating uses the raw strobe so the mask lines up with the data word;
  // the filtered strobe lags by the filter depth
  always_comb begin
    pix_d = pixel_data_i;
    if (gate_on && !pixel_valid_strobe_i) begin
      pix_d = 24'h000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pix_q <= 24'h000000;
    end else begin
      pix_q <= pix_d;
    end
  end

  assign pixel_data_o = pix_q;

  // pass-through and acknowledge decisions for the local i2c target
  logic fwd_q;
  logic fwd_d;
  logic ack_q;
  logic ack_d;

  always_comb begin
    fwd_d = 1'b0;
    ack_d = ack_q;
    if (i2c_txn_start_i) begin
      // forward-all overrides the address decode
      fwd_d = pass_all | (pass_matched & i2c_addr_match_i);
      if (pass_all) begin
        fwd_d = 1'b1;
      end
      // writes are acked when locked, or always with auto-acknowledge
      ack_d = i2c_write_i & (auto_ack | fwd_locked_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fwd_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      fwd_q <= fwd_d;
      ack_q <= ack_d;
    end
  end

  assign i2c_forward_o   = fwd_q;
  assign i2c_write_ack_o = ack_q;

  // control channel watchdog: a prescaler makes step ticks, a step count
  // is compared against the programmed timeout
  lgicr_pkg::lgicr_wd_state_type wd_state_q;
  lgicr_pkg::lgicr_wd_state_type wd_state_d;
  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [6:0]  steps_q;
  logic [6:0]  steps_d;
  logic        abort_q;
  logic        abort_d;
  logic        step_tick;

  assign step_tick = (pre_q == WDOG_STEP_CYC - 1);

  always_comb begin
    wd_state_d = wd_state_q;
    pre_d      = 32'h00000000;
    steps_d    = 7'h00;
    abort_d    = 1'b0;
    case (wd_state_q)
      lgicr_pkg::WD_IDLE: begin
        if (cc_txn_busy_i && !return_path_timeout_off) begin
          wd_state_d = lgicr_pkg::WD_COUNT;
        end
      end
      lgicr_pkg::WD_COUNT: begin
        if (!cc_txn_busy_i || return_path_timeout_off) begin
          wd_state_d = lgicr_pkg::WD_IDLE;
        end else if (steps_q >= return_path_timeout) begin
          // a zero field would abort at once; software must avoid it
          abort_d    = 1'b1;
          wd_state_d = lgicr_pkg::WD_EXPIRED;
        end else begin
          steps_d = steps_q;
          pre_d   = pre_q + 32'h00000001;
          if (step_tick) begin
            pre_d   = 32'h00000000;
            steps_d = steps_q + 7'h01;
          end
        end
      end
      lgicr_pkg::WD_EXPIRED: begin
        // hold off until the aborted transaction is released
        if (!cc_txn_busy_i) begin
          wd_state_d = lgicr_pkg::WD_IDLE;
        end
      end
      default: begin
        wd_state_d = lgicr_pkg::WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wd_state_q <= lgicr_pkg::WD_IDLE;
      pre_q      <= 32'h00000000;
      steps_q    <= 7'h00;
      abort_q    <= 1'b0;
    end else begin
      wd_state_q <= wd_state_d;
      pre_q      <= pre_d;
      steps_q    <= steps_d;
      abort_q    <= abort_d;
    end
  end

  assign cc_txn_abort_o = abort_q;

endmodule // lgicr_regs

// file: design/lgicr_pkg.sv
// package for the link general and i2c configuration register bank
// assumes one 125 mhz clock and a local register port from the i2c target
package lgicr_pkg;

  // register offsets on the local register port
  localparam logic [7:0] OFS_GEN_CFG_ONE  = 8'h03;
  localparam logic [7:0] OFS_TIMEOUT_CTRL = 8'h04;
  localparam logic [7:0] OFS_I2C_CTRL_ONE = 8'h05;
  localparam logic [7:0] OFS_I2C_CTRL_TWO = 8'h06;

  // values after reset
  localparam logic [7:0] RST_GEN_CFG_ONE  = 8'hf0;
  localparam logic [7:0] RST_TIMEOUT_CTRL = 8'hfe;
  localparam logic [7:0] RST_I2C_CTRL_ONE = 8'h1e;
  localparam logic [7:0] RST_I2C_CTRL_TWO = 8'h00;

  // general_config_one field positions
  localparam int unsigned GC_RSVD_RW_BIT   = 7;
  localparam int unsigned GC_CRC_GEN_BIT   = 6;
  localparam int unsigned GC_PULL_SEL_BIT  = 5;
  localparam int unsigned GC_FILTER_BIT    = 4;
  localparam int unsigned GC_PASS_BIT      = 3;
  localparam int unsigned GC_AUTO_ACK_BIT  = 2;
  localparam int unsigned GC_GATE_BIT      = 1;
  localparam logic [7:0]  GC_WRITE_MASK    = 8'hfe;

  // control_channel_timeout_ctrl fields
  localparam int unsigned TO_FIELD_LSB     = 1;
  localparam int unsigned TO_OFF_BIT       = 0;

  // i2c_control_one fields
  localparam int unsigned IC_PASS_ALL_BIT  = 7;
  localparam int unsigned IC_HOLD_LSB      = 4;
  localparam int unsigned IC_FILTER_LSB    = 0;

  // pulse filter widths in pixel clocks
  localparam logic [2:0] FILT_W_SYNC   = 3'h2;
  localparam logic [2:0] FILT_W_LINE_1 = 3'h2;
  localparam logic [2:0] FILT_W_LINE_2 = 3'h4;

  // watchdog step time and clock
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam longint unsigned WDOG_STEP_MS = 2;
  localparam int unsigned WDOG_STEP_CYC =
    int'((WDOG_STEP_MS * 64'd1000000000) / CLK_PERIOD_PS);

  // i2c pad timing units, in ns, for the pad block that consumes the fields
  localparam int unsigned SDA_HOLD_UNIT_NS  = 50;
  localparam int unsigned GLITCH_UNIT_NS    = 5;

  // watchdog states
  typedef enum logic [2:0] {
    WD_IDLE    = 3'b001,
    WD_COUNT   = 3'b010,
    WD_EXPIRED = 3'b100
  } lgicr_wd_state_type;

endpackage // lgicr_pkg

// file: design/lgicr_pulse_filter.sv
// pulse filter: output follows input only once the new level has held
// for width_i consecutive clocks; with en_i low it is a plain register
module lgicr_pulse_filter (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       en_i,
  input  wire logic [2:0] width_i,
  // data
  input  wire logic       d_i,
  output logic            q_o
);

  logic       q_q;
  logic       q_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // count how long the input has differed from the output
  always_comb begin
    q_d   = q_q;
    cnt_d = 3'h0;
    if (!en_i) begin
      q_d = d_i;
    end else if (d_i != q_q) begin
      // a pulse shorter than width never reaches the output
      if (cnt_q + 3'h1 >= width_i) begin
        q_d = d_i;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_q   <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      q_q   <= q_d;
      cnt_q <= cnt_d;
    end
  end

  assign q_o = q_q;

endmodule // lgicr_pulse_filter

// file: testbench/lgicr_regs_chk.sv
// checker bound to lgicr_regs, watching its ports only
// assumes one clock domain with a synchronous active-low reset
module lgicr_regs_chk #(
  parameter int unsigned WDOG_STEP_CYC = 4
) (
  // clock, reset, register writes
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  // link status and i2c decision
  input wire logic       fwd_locked_i,
  input wire logic       return_path_on_i,
  input wire logic       i2c_txn_start_i,
  input wire logic       i2c_addr_match_i,
  input wire logic       i2c_write_i,
  input wire logic       i2c_forward_o,
  input wire logic       i2c_write_ack_o,
  // sync, watchdog and static controls
  input wire logic       frame_sync_i,
  input wire logic       frame_sync_o,
  input wire logic       cc_txn_busy_i,
  input wire logic       cc_txn_abort_o,
  input wire logic       undriven_pull_down_o,
  input wire logic       return_crc_gen_on_o,
  input wire logic       return_path_active_o,
  input wire logic [2:0] sda_hold_steps_o,
  input wire logic [3:0] glitch_reject_steps_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  s3_q, s3_d, s4_q, s4_d, s5_q, s5_d;
  logic [15:0] run_q, run_d, due;
  logic        fwd_exp, ack_exp;

  // shadow registers and busy run length; saturates so it never wraps
  always_comb begin
    s3_d = s3_q;
    s4_d = s4_q;
    s5_d = s5_q;
    if (reg_wr_i && reg_addr_i == lgicr_pkg::OFS_GEN_CFG_ONE)
      s3_d = reg_wdata_i & lgicr_pkg::GC_WRITE_MASK;
    if (reg_wr_i && reg_addr_i == lgicr_pkg::OFS_TIMEOUT_CTRL)
      s4_d = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == lgicr_pkg::OFS_I2C_CTRL_ONE)
      s5_d = reg_wdata_i;
    run_d = '0;
    if (cc_txn_busy_i && !s4_q[0])
      run_d = (run_q == 16'hffff) ? run_q : run_q + 16'h1;
    if (!rst_n_i) begin
      s3_d  = lgicr_pkg::RST_GEN_CFG_ONE;
      s4_d  = lgicr_pkg::RST_TIMEOUT_CTRL;
      s5_d  = lgicr_pkg::RST_I2C_CTRL_ONE;
      run_d = '0;
    end
    due = 16'(2 + s4_q[7:1] * WDOG_STEP_CYC);
    fwd_exp = s5_q[7] | (s3_q[3] & i2c_addr_match_i);
    ack_exp = i2c_write_i & (s3_q[2] | fwd_locked_i);
  end

  // register stage of the helper state
  always_ff @(posedge clk_i) begin
    s3_q  <= s3_d;
    s4_q  <= s4_d;
    s5_q  <= s5_d;
    run_q <= run_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // a transaction start, decided on the next edge
  sequence s_start;
    i2c_txn_start_i;
  endsequence

  a_fwd_decide: assert property (
    s_start |=> i2c_forward_o == $past(fwd_exp))
    else $error("forward decision wrong");
  a_fwd_quiet: assert property (
    !i2c_txn_start_i |=> !i2c_forward_o)
    else $error("forward without a start");
  a_write_ack: assert property (
    s_start |=> i2c_write_ack_o == $past(ack_exp))
    else $error("write acknowledge wrong");
  a_ret_path: assert property (
    return_path_active_o == (return_path_on_i | s3_q[3] | s5_q[7]))
    else $error("return path enable wrong");
  a_static_out: assert property (
    {undriven_pull_down_o, return_crc_gen_on_o, sda_hold_steps_o,
     glitch_reject_steps_o} == {s3_q[5], s3_q[6], s5_q[6:0]})
    else $error("static control outputs wrong");
  a_frame_filt: assert property (
    $rose(frame_sync_o) && $past(s3_q[4])
    |-> $past(frame_sync_i) && $past(frame_sync_i, 2))
    else $error("short frame sync pulse passed");
  a_abort_when: assert property (
    cc_txn_abort_o |-> run_q == due)
    else $error("abort at wrong time");
  a_abort_due: assert property (
    run_q == due |-> cc_txn_abort_o)
    else $error("abort missing at timeout");
endmodule // lgicr_regs_chk

bind lgicr_regs lgicr_regs_chk #(.WDOG_STEP_CYC(WDOG_STEP_CYC))
  lgicr_regs_chk_i (.*);

// file: testbench/lgicr_ser_model.sv
// model of the remote serializer across the control channel
// assumes a forward pulse opens a transaction and an abort closes it
module lgicr_ser_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // transaction control
  input  wire logic fwd_i,
  input  wire logic abort_i,
  input  wire logic slow_i,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] age_q;

  // prompt answers after four cycles; slow only frees on abort
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      age_q  <= 4'h0;
    end else if (fwd_i && !busy_o) begin
      busy_o <= 1'b1;
      age_q  <= 4'h0;
    end else if (busy_o) begin
      age_q <= age_q + 4'h1;
      if (abort_i || (!slow_i && age_q == 4'h3))
        busy_o <= 1'b0;
    end
  end
endmodule // lgicr_ser_model

// file: testbench/tb_lgicr_regs.sv
// self-checking bench for lgicr_regs with a serializer model
// assumes a 125 mhz clock and a shortened watchdog step
`define CHK(nm, ex, got) begin \
  num_checks++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end \
end

module tb_lgicr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STEP = 4;
  logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i, dual_lane_i;
  logic        partner_protected_i, fwd_locked_i, return_path_on_i;
  logic        pixel_valid_strobe_i, line_sync_i, frame_sync_i;
  logic        pixel_valid_strobe_o, line_sync_o, frame_sync_o;
  logic        i2c_txn_start_i, i2c_addr_match_i, i2c_write_i;
  logic        i2c_forward_o, i2c_write_ack_o, cc_txn_busy_i;
  logic        cc_txn_abort_o, undriven_pull_down_o, return_crc_gen_on_o;
  logic        return_path_active_o, partner_slow;
  logic [2:0]  sda_hold_steps_o;
  logic [3:0]  glitch_reject_steps_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [23:0] pixel_data_i, pixel_data_o;
  logic [7:0]  rst_tab [5] = '{8'hf0, 8'hfe, 8'h1e, 8'h00, 8'h00};
  logic [7:0]  sync_tab [11] = '{8'h82, 8'h85, 8'h92, 8'h95, 8'ha2,
                                 8'ha5, 8'hd6, 8'hd9, 8'he5, 8'h23, 8'h13};
  int          errors, num_checks;

  lgicr_regs #(.WDOG_STEP_CYC(STEP)) lgicr_regs_i (.*);
  lgicr_ser_model lgicr_ser_model_i (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fwd_i   (i2c_forward_o),
    .abort_i (cc_txn_abort_o),
    .slow_i  (partner_slow),
    .busy_o  (cc_txn_busy_i)
  );

  // free running clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // strobe cycle then an idle cycle, so strobes never retoggle at once
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] ex);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    tick();
    `CHK("rdata", ex, reg_rdata_o)
  endtask

  // one pulse on a chosen sync input; e = filt, dual, sel, len, expect
  task automatic sync_try(logic [7:0] e);
    logic seen;
    seen = 1'b0;
    wr(lgicr_pkg::OFS_GEN_CFG_ONE, {3'b100, e[7], 4'h0});
    dual_lane_i = e[6];
    for (int c = 0; c < 10; c++) begin
      {pixel_valid_strobe_i, line_sync_i, frame_sync_i} =
        (c < e[3:1]) ? 3'b100 >> e[5:4] : 3'b000;
      tick();
      seen |= |({pixel_valid_strobe_o, line_sync_o, frame_sync_o}
                & (3'b100 >> e[5:4]));
    end
    `CHK("sync pulse", e[0], seen)
  endtask

  // open a transaction, count cycles from busy to abort (80 = none)
  task automatic wd_try(logic [7:0] to, logic sl, int ex);
    int n;
    n = 0;
    wr(lgicr_pkg::OFS_TIMEOUT_CTRL, to); // never zero
    partner_slow = sl;
    i2c_addr_match_i = 1'b1;
    i2c_txn_start_i = 1'b1;
    tick();
    i2c_txn_start_i = 1'b0;
    tick();
    while (!cc_txn_abort_o && n < 80) begin
      tick();
      n++;
    end
    `CHK("abort delay", ex, n)
    partner_slow = 1'b0;
    tick(20);
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #160000;
    errors++;
    tally_and_finish();
  end

  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, dual_lane_i, partner_protected_i,
     fwd_locked_i, return_path_on_i, pixel_valid_strobe_i, line_sync_i,
     frame_sync_i, i2c_txn_start_i, i2c_addr_match_i, i2c_write_i,
     partner_slow, reg_addr_i, reg_wdata_i, pixel_data_i} = '0;
    tick(2);
    rst_n_i = 1'b1;
    // reset values, the omitted register and an unmapped offset
    foreach (rst_tab[k]) rd(8'(k + 3), rst_tab[k]);
    `CHK("statics", 9'h19e, {undriven_pull_down_o, return_crc_gen_on_o,
      sda_hold_steps_o, glitch_reject_steps_o})
    wr(lgicr_pkg::OFS_GEN_CFG_ONE, 8'h81);
    rd(lgicr_pkg::OFS_GEN_CFG_ONE, 8'h80);
    `CHK("pull crc", 2'b00,
      {undriven_pull_down_o, return_crc_gen_on_o})
    wr(lgicr_pkg::OFS_I2C_CTRL_ONE, 8'h6a);
    rd(lgicr_pkg::OFS_I2C_CTRL_ONE, 8'h6a);
    `CHK("pads", 7'h6a,
      {sda_hold_steps_o, glitch_reject_steps_o})
    wr(lgicr_pkg::OFS_I2C_CTRL_TWO, 8'hff);
    rd(lgicr_pkg::OFS_I2C_CTRL_TWO, 8'h00);
    // every mix of pass bits, match, auto-ack and lock
    for (int i = 0; i < 32; i++) begin
      wr(lgicr_pkg::OFS_GEN_CFG_ONE, {4'h8, i[0], i[3], 2'b00});
      wr(lgicr_pkg::OFS_I2C_CTRL_ONE, {i[1], 7'h1e});
      i2c_addr_match_i = i[2];
      fwd_locked_i = i[4];
      return_path_on_i = i[4] & i[3];
      i2c_write_i = ~(i[0] & i[2]);
      i2c_txn_start_i = 1'b1;
      tick();
      i2c_txn_start_i = 1'b0;
      `CHK("forward", i[1] | (i[0] & i[2]),
        i2c_forward_o)
      `CHK("ack", i2c_write_i & (i[3] | i[4]),
        i2c_write_ack_o)
      `CHK("ret path", i[0] | i[1] | (i[4] & i[3]),
        return_path_active_o)
      tick();
      `CHK("forward pulse", 1'b0, i2c_forward_o)
    end
    // pixel gating against partner kind, gate bit and valid strobe
    pixel_data_i = 24'ha5c3f1;
    for (int j = 0; j < 8; j++) begin
      wr(lgicr_pkg::OFS_GEN_CFG_ONE, {6'h21, j[1], 1'b0});
      partner_protected_i = j[0];
      pixel_valid_strobe_i = j[2];
      tick();
      `CHK("pixels", ((j[0] | j[1]) & !j[2]) ? 24'h0 : 24'ha5c3f1,
        pixel_data_o)
    end
    pixel_valid_strobe_i = 1'b0;
    foreach (sync_tab[k]) sync_try(sync_tab[k]);
    wr(lgicr_pkg::OFS_GEN_CFG_ONE, 8'h88);
    wd_try(8'h06, 1'b1, 2 + 3 * STEP);
    wd_try(8'h02, 1'b1, 2 + STEP);
    wd_try(8'h06, 1'b0, 80);
    wd_try(8'h07, 1'b1, 80);
    tally_and_finish();
  end
endmodule // tb_lgicr_regs
